// >>> mrs_pkg.sv
// package: register map, state codes and timing constants of the memory reset sequencer
package mrs_pkg;

    // ======================================================================
    // register map (byte addresses)
    localparam logic [7:0]  EXT_OFFSET     = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
    localparam logic [7:0]  NVCFG_OFFSET   = 8'h08;
    localparam logic [15:0] EXT_RESET      = 16'hFFFF;
    localparam logic [15:0] EXT_NONE       = 16'hFFFF;
    localparam logic [15:0] NVCFG_RESET    = 16'h0000;

    // status fields
    localparam int STAT_STATE_LSB  = 0;
    localparam int STAT_POR_OK     = 4;
    localparam int STAT_OTP_DONE   = 5;
    localparam int STAT_OTP_FAIL   = 6;
    localparam int STAT_SYSRST     = 7;

    // ======================================================================
    // timing
    localparam longint CLK_PERIOD_PS       = 25000;
    localparam longint POWER_SETTLE_US     = 300;
    localparam longint RESET_RECOVERY_US   = 30;
    localparam longint RESET_PULSE_NS      = 200;
    localparam longint EXT_TICK_US         = 32;
    localparam longint DEEP_WAKE_US        = 300;

    // least times round up, longest times round down
    localparam logic [15:0] SETTLE_CYC =
        16'((POWER_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [15:0] RECOVERY_CYC =
        16'((RESET_RECOVERY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [15:0] PULSE_CYC =
        16'((RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [15:0] TICK_CYC =
        16'((EXT_TICK_US * 1000000) / CLK_PERIOD_PS);
    localparam logic [15:0] WAKE_CYC =
        16'((DEEP_WAKE_US * 1000000) / CLK_PERIOD_PS);

    // ======================================================================
    // sequencer states
    typedef enum logic [3:0] {
        ST_POR_SETTLE  = 4'h0,
        ST_POR_EXTEND  = 4'h1,
        ST_POR_RECOVER = 4'h2,
        ST_STANDBY     = 4'h3,
        ST_WARM        = 4'h4,
        ST_HW_RESET    = 4'h5,
        ST_DEEP_DOWN   = 4'h6,
        ST_DEEP_WAKE   = 4'h7
    } mrs_state_type;

endpackage

// >>> mrs_sequencer.sv
// reset and power sequencer of a serial flash memory, with an APB register slave
//
// Functional notes
// - reset pin and select ignored during settling and extended reset-out low.
// - no selection or commands, no outputs but reset-out, during power-on reset.
// - reset low during power-on: finish after settling and recovery; recovery from pin release, or from end of settling and extension if pin still low.
// - settle end: stay in hardware reset if pin low, else standby.
// - select level during settling never changes the cold reset.
// - unfinished power-on: later hardware reset reruns full cold reset.
// - reset-out held low in settling and extension, released when they end, before any power-on recovery.
// - extension lasts (count plus one) ticks of 25 to 42 microseconds.
// - count FFFFh adds no extension; release at settle end.
// - extension count programs once; later attempts fail.
// - interrupt output high impedance once supply is good.
// - hardware reset aborts, leaves alternate space, tristates, clears status, idles controller.
// - select ignored for the whole recovery after hardware reset.
// - reset pin low blocks commands and reads.
// - hardware reset reloads bus configuration from non-volatile copy.
// - reset after power-on runs short warm reset without algorithm reload.
// - after warm reset: hold while pin low, standby when high.
// - reset pulse wakes deep power-down into standby with power-on defaults.
// - wake from deep power-down within 300 microseconds.
module mrs_sequencer
    import mrs_pkg::*;
#(
    parameter logic [15:0] SETTLE_CYCLES   = mrs_pkg::SETTLE_CYC,
    parameter logic [15:0] RECOVERY_CYCLES = mrs_pkg::RECOVERY_CYC,
    parameter logic [15:0] PULSE_CYCLES    = mrs_pkg::PULSE_CYC,
    parameter logic [15:0] TICK_CYCLES     = mrs_pkg::TICK_CYC,
    parameter logic [15:0] WAKE_CYCLES     = mrs_pkg::WAKE_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    // pins and supply monitor
    input  wire logic        power_good_i,
    input  wire logic        hw_reset_n_i,
    input  wire logic        chip_select_n_i,
    output logic             system_reset_out_n_o,
    output logic             system_reset_out_n_oe_o,
    output logic             interrupt_n_o,
    output logic             interrupt_n_oe_o,
    // core side
    input  wire logic        deep_power_down_i,
    output logic             select_accept_o,
    output logic             command_block_o,
    output logic             output_enable_allow_o,
    output logic             warm_reset_o,
    output logic             cold_reset_o,
    output logic [15:0]      bus_config_o,
    output mrs_pkg::mrs_state_type state_o,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o
);
    import mrs_pkg::*;

    // ======================================================================
    // pin synchronisers
    logic [1:0] pg_sync;
    logic [1:0] rst_sync;
    logic [1:0] cs_sync;
    logic       pwr_ok;
    logic       rst_n;
    logic       cs_n;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pg_sync  <= 2'h0;
            // pin idles high: a low reset value would fake a pin pulse after every cold start
            rst_sync <= 2'h3;
            cs_sync  <= 2'h3;
        end else begin
            pg_sync  <= {pg_sync[0], power_good_i};
            rst_sync <= {rst_sync[0], hw_reset_n_i};
            cs_sync  <= {cs_sync[0], chip_select_n_i};
        end
    end

    assign pwr_ok = pg_sync[1];
    assign rst_n  = rst_sync[1];
    assign cs_n   = cs_sync[1];

    // ======================================================================
    // registers
    mrs_state_type state;
    mrs_state_type next_state;
    logic [15:0]   cnt;
    logic [16:0]   ext_tick;
    logic [15:0]   rec_cnt;
    logic          rst_seen;
    logic          brownout;
    logic          por_ok;
    logic [15:0]   reset_extension_count;
    logic          otp_done;
    logic          otp_fail;
    logic [15:0]   nonvolatile_bus_config;
    logic          sysrst_active;

    logic          settle_end;
    logic          extend_end;
    logic          rec_done;
    logic          leave;
    logic          in_por;
    mrs_state_type post_por;

    assign in_por     = (state == ST_POR_SETTLE) || (state == ST_POR_EXTEND);
    assign settle_end = (state == ST_POR_SETTLE) && pwr_ok && (cnt == SETTLE_CYCLES - 16'h0001);
    assign extend_end = (state == ST_POR_EXTEND) && (cnt == TICK_CYCLES - 16'h0001)
                        && (ext_tick == {1'b0, reset_extension_count});
    assign rec_done   = (rec_cnt >= RECOVERY_CYCLES);
    assign leave      = (next_state != state);
    // recovery still owed when the pin was seen low
    assign post_por   = (rst_seen || !rst_n) ? ST_POR_RECOVER : ST_STANDBY;

    // ======================================================================
    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_POR_SETTLE: begin
                // pin and select play no part until settling ends
                if (settle_end) begin
                    if (reset_extension_count != EXT_NONE) begin
                        next_state = ST_POR_EXTEND;
                    end else begin
                        next_state = post_por;
                    end
                end
            end
            ST_POR_EXTEND: begin
                if (extend_end) begin
                    next_state = post_por;
                end
            end
            ST_POR_RECOVER: begin
                // pin still low holds hardware reset
                if (rec_done) begin
                    next_state = rst_n ? ST_STANDBY : ST_HW_RESET;
                end
            end
            ST_STANDBY: begin
                if (!rst_n) begin
                    // unfinished power-on reruns the cold reset
                    next_state = por_ok ? ST_WARM : ST_POR_SETTLE;
                end else if (deep_power_down_i) begin
                    next_state = ST_DEEP_DOWN;
                end
            end
            ST_WARM: begin
                // leave to standby only with pin high
                if (cnt == RECOVERY_CYCLES - 16'h0001) begin
                    next_state = rst_n ? ST_STANDBY : ST_HW_RESET;
                end
            end
            ST_HW_RESET: begin
                if (rst_n) begin
                    next_state = ST_STANDBY;
                end
            end
            ST_DEEP_DOWN: begin
                // a full-width pulse starts the wake
                if (!rst_n && cnt == PULSE_CYCLES - 16'h0001) begin
                    next_state = ST_DEEP_WAKE;
                end
            end
            ST_DEEP_WAKE: begin
                // wake bounded by the longest wake time
                if (cnt == WAKE_CYCLES - 16'h0001) begin
                    next_state = rst_n ? ST_STANDBY : ST_HW_RESET;
                end
            end
            default: next_state = ST_POR_SETTLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_POR_SETTLE;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================================
    // one shared counter on the core clock
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt      <= 16'h0000;
            ext_tick <= 17'h00000;
        end else if (leave) begin
            cnt      <= 16'h0000;
            ext_tick <= 17'h00000;
        end else begin
            unique case (state)
                // settling counts only on a good supply
                ST_POR_SETTLE: cnt <= pwr_ok ? cnt + 16'h0001 : cnt;
                ST_POR_EXTEND: begin
                    if (cnt == TICK_CYCLES - 16'h0001) begin
                        cnt      <= 16'h0000;
                        ext_tick <= ext_tick + 17'h00001;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                ST_WARM, ST_DEEP_WAKE: cnt <= cnt + 16'h0001;
                ST_DEEP_DOWN: cnt <= rst_n ? 16'h0000 : cnt + 16'h0001;
                default: cnt <= 16'h0000;
            endcase
        end
    end

    // recovery restarts while the pin is low during settling
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rec_cnt  <= 16'h0000;
            rst_seen <= 1'b0;
        end else if (in_por) begin
            rst_seen <= rst_seen || !rst_n;
            rec_cnt  <= (!rst_n || rec_done) ? (rst_n ? rec_cnt : 16'h0000)
                                             : (rst_seen ? rec_cnt + 16'h0001 : rec_cnt);
        end else if (state == ST_POR_RECOVER) begin
            rec_cnt <= rec_done ? rec_cnt : rec_cnt + 16'h0001;
        end else begin
            rec_cnt  <= 16'h0000;
            rst_seen <= 1'b0;
        end
    end

    // a supply drop in mid-settle leaves power-on unfinished
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            brownout <= 1'b0;
            por_ok   <= 1'b0;
        end else if (next_state == ST_POR_SETTLE && state != ST_POR_SETTLE) begin
            brownout <= 1'b0;
            por_ok   <= 1'b0;
        end else begin
            if (state == ST_POR_SETTLE && cnt != 16'h0000 && !pwr_ok) begin
                brownout <= 1'b1;
            end
            if ((in_por || state == ST_POR_RECOVER) && leave && next_state != ST_POR_EXTEND
                    && next_state != ST_POR_RECOVER) begin
                por_ok <= !brownout;
            end
        end
    end

    // ======================================================================
    // reset effects
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            warm_reset_o  <= 1'b0;
            cold_reset_o  <= 1'b0;
            bus_config_o  <= NVCFG_RESET;
            sysrst_active <= 1'b1;
        end else begin
            // abort, leave alternate space, clear status, idle controller
            // warm entry carries no algorithm reload
            warm_reset_o  <= (next_state == ST_WARM) && (state != ST_WARM);
            // deep wake exit restores power-on defaults
            cold_reset_o  <= ((next_state == ST_POR_SETTLE) && (state == ST_STANDBY))
                             || ((state == ST_DEEP_WAKE) && leave);
            // bus configuration reloaded from non-volatile copy
            if (((next_state == ST_WARM) && (state != ST_WARM))
                    || ((next_state == ST_POR_SETTLE) && (state != ST_POR_SETTLE))
                    || ((state == ST_DEEP_WAKE) && leave)) begin
                bus_config_o <= nonvolatile_bus_config;
            end
            // held low through settling and extension only
            sysrst_active <= (next_state == ST_POR_SETTLE) || (next_state == ST_POR_EXTEND);
        end
    end

    // open drain: only ever pulls low
    assign system_reset_out_n_o    = 1'b0;
    assign system_reset_out_n_oe_o = sysrst_active;
    // interrupt pin never driven by this block
    assign interrupt_n_o           = 1'b0;
    assign interrupt_n_oe_o        = 1'b0;

    // only standby with pin high accepts anything
    assign select_accept_o       = (state == ST_STANDBY) && rst_n && !sysrst_active && !cs_n;
    assign command_block_o       = (state != ST_STANDBY) || !rst_n || sysrst_active;
    assign output_enable_allow_o = !command_block_o;
    assign state_o               = state;

    // ======================================================================
    // APB slave, zero wait states
    logic wr_access;

    assign wr_access = psel_i && penable_i && pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i
                       && !(paddr_i == EXT_OFFSET || paddr_i == STATUS_OFFSET
                            || paddr_i == NVCFG_OFFSET);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reset_extension_count  <= EXT_RESET;
            otp_done               <= 1'b0;
            otp_fail               <= 1'b0;
            nonvolatile_bus_config <= NVCFG_RESET;
        end else if (wr_access) begin
            unique case (paddr_i)
                EXT_OFFSET: begin
                    // one program only; later attempts flag a failure
                    if (!otp_done) begin
                        reset_extension_count <= pwdata_i[15:0];
                        otp_done              <= 1'b1;
                    end else begin
                        otp_fail <= 1'b1;
                    end
                end
                STATUS_OFFSET: begin
                    if (pwdata_i[STAT_OTP_FAIL]) begin
                        otp_fail <= 1'b0;
                    end
                end
                NVCFG_OFFSET: nonvolatile_bus_config <= pwdata_i[15:0];
                default: ;
            endcase
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o <= 32'h00000000;
        end else if (psel_i && !penable_i) begin
            unique case (paddr_i)
                EXT_OFFSET:   prdata_o <= {16'h0000, reset_extension_count};
                NVCFG_OFFSET: prdata_o <= {16'h0000, nonvolatile_bus_config};
                STATUS_OFFSET: prdata_o <= {24'h000000, sysrst_active, otp_fail,
                                            otp_done, por_ok, state};
                default:      prdata_o <= 32'h00000000;
            endcase
        end
    end

    // ======================================================================
    // checks
    logic [31:0] ext_len;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_len <= 32'h00000000;
        end else begin
            ext_len <= (state == ST_POR_EXTEND) ? ext_len + 32'h00000001 : 32'h00000000;
        end
    end

    sysrst_block_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        system_reset_out_n_oe_o |-> !select_accept_o && command_block_o)
        else $error("selection accepted while reset-out is low");

    settle_hold_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (state == ST_POR_SETTLE && cnt < SETTLE_CYCLES - 16'h0001)
        |=> state == ST_POR_SETTLE && system_reset_out_n_oe_o)
        else $error("settling left early");

    recover_hold_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (state == ST_POR_RECOVER && !rec_done) |=> state == ST_POR_RECOVER)
        else $error("power-on recovery cut short");

    recover_exit_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (state == ST_POR_RECOVER && rec_done) |=>
        state == ($past(rst_n) ? ST_STANDBY : ST_HW_RESET))
        else $error("wrong state after power-on recovery");

    ext_length_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (state == ST_POR_EXTEND && leave) |->
        ext_len + 32'h00000001 == ({16'h0000, reset_extension_count} + 32'h00000001)
                                  * {16'h0000, TICK_CYCLES})
        else $error("extension length wrong");

    no_extend_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (settle_end && reset_extension_count == EXT_NONE) |=> !system_reset_out_n_oe_o)
        else $error("reset-out held with erased count");

    otp_once_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_access && paddr_i == EXT_OFFSET && otp_done) |=>
        $stable(reset_extension_count) && otp_fail)
        else $error("extension count reprogrammed");

    int_float_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pwr_ok |-> !interrupt_n_oe_o)
        else $error("interrupt pin driven");

    warm_effects_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (state == ST_STANDBY && !rst_n && por_ok) |=>
        warm_reset_o && !cold_reset_o && bus_config_o == $past(nonvolatile_bus_config))
        else $error("warm reset effects missing");

    warm_hold_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (state == ST_WARM && cnt < RECOVERY_CYCLES - 16'h0001) |=>
        state == ST_WARM && !select_accept_o)
        else $error("select accepted during recovery");

    pin_block_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !rst_n |-> command_block_o && !select_accept_o)
        else $error("commands pass with reset pin low");

    cold_rerun_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (state == ST_STANDBY && !rst_n && !por_ok) |=> state == ST_POR_SETTLE ##1
        system_reset_out_n_oe_o)
        else $error("unfinished power-on not rerun");

    wake_bound_a: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (state == ST_DEEP_WAKE && cnt == WAKE_CYCLES - 16'h0001) |=>
        state != ST_DEEP_WAKE && cold_reset_o)
        else $error("deep wake overran");

    por_extend_c: cover property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        state == ST_POR_EXTEND ##1 state == ST_STANDBY);
    warm_reset_c: cover property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        state == ST_WARM ##1 state == ST_HW_RESET);
    deep_wake_c: cover property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        state == ST_DEEP_WAKE ##1 state == ST_STANDBY);
    otp_fail_c: cover property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        $rose(otp_fail));

endmodule

// >>> mrs_host.sv
// host memory controller model: drives reset pin and chip select
module mrs_host (
    input  wire logic clk_i,
    input  wire logic rst_out_oe_i,
    output logic      hw_reset_n_o,
    output logic      chip_select_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hw_reset_n_o    = 1'b1;
        chip_select_n_o = 1'b1;
    end
    // caller gives low width in cycles
    task automatic pulse(input int lo);
        hw_reset_n_o <= 1'b0;
        repeat (lo) @(posedge clk_i);
        hw_reset_n_o <= 1'b1;
    endtask
    // with obey set, wait high gap and reset-out release; then one select
    task automatic select(input logic obey);
        if (obey) begin
            repeat (6) @(posedge clk_i);
            while (rst_out_oe_i) @(posedge clk_i);
        end
        chip_select_n_o <= 1'b0;
        @(posedge clk_i);
        chip_select_n_o <= 1'b1;
    endtask
endmodule

// >>> testbench.sv
// self-checking bench of the memory reset sequencer
module testbench;
    import mrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // short counts keep the run small
    localparam int S = 40, R = 10, T = 4, W = 20, P = 3;
    logic        clk = 1'b0, arst_n = 1'b0, pg = 1'b1, ddn = 1'b0;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic        oe, acc, blk, allow, warm, cold, irq_oe, pready, perr;
    logic [15:0] cfg, v;
    mrs_state_type st;
    wire         hw_n, cs_n;
    logic [64:0] q[$];
    int          n_fail = 0, n_checks = 0, cyc = 0, t0;

    mrs_sequencer #(.SETTLE_CYCLES(16'(S)), .RECOVERY_CYCLES(16'(R)), .PULSE_CYCLES(16'(P)),
        .TICK_CYCLES(16'(T)), .WAKE_CYCLES(16'(W))) u_dut (
        .core_clk_i(clk), .arst_n_i(arst_n), .power_good_i(pg), .hw_reset_n_i(hw_n),
        .chip_select_n_i(cs_n), .system_reset_out_n_o(), .system_reset_out_n_oe_o(oe),
        .interrupt_n_o(), .interrupt_n_oe_o(irq_oe), .deep_power_down_i(ddn),
        .select_accept_o(acc), .command_block_o(blk), .output_enable_allow_o(allow),
        .warm_reset_o(warm), .cold_reset_o(cold), .bus_config_o(cfg), .state_o(st),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(rd), .pready_o(pready), .pslverr_o(perr));
    mrs_host u_host (.clk_i(clk), .rst_out_oe_i(oe), .hw_reset_n_o(hw_n), .chip_select_n_o(cs_n));

    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // ======================================================================
    // shared tasks
    task automatic chk(input logic [32:0] g, e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t ns: got %h, want %h", $time, g, e);
        end
    endtask
    task automatic test_done();
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // read notes {error, mask, data} for the monitor
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, m, e);
        int n = 0;
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        if (!w) q.push_back({a > 8'h08, m, e});
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic until_st(input mrs_state_type s, input int lim);
        int n = 0;
        while (st !== s && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(st, s);
    endtask
    task automatic cold_start();
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t0 = cyc;
    endtask

    // ======================================================================
    // monitor
    always @(posedge clk) begin
        if (psel && pen && pready && !pwr) begin
            chk({perr, rd & q[0][63:32]}, {q[0][64], q[0][31:0]});
            void'(q.pop_front());
        end
        if (arst_n && acc === 1'b1 && (st !== ST_STANDBY || oe !== 1'b0)) chk(1, 0);
        chk({blk, irq_oe}, {~allow, 1'b0});
    end

    // ======================================================================
    // scenarios
    initial begin
        v = 16'($urandom(32'h115d));
        cold_start();
        u_host.select(1'b0);
        apb(0, EXT_OFFSET, 0, 32'hFFFF, 32'hFFFF);
        apb(0, STATUS_OFFSET, 0, 32'h8F, 32'h80);
        until_st(ST_STANDBY, 2 * S);
        chk({(cyc - t0) inside {[S:S + 5]}, oe}, 2'b10);
        v = 16'($urandom);
        apb(1, NVCFG_OFFSET, {16'h0, v}, 0, 0);
        fork u_host.pulse(P + $urandom_range(4)); join_none
        until_st(ST_WARM, 10);
        t0 = cyc;
        chk({warm, cfg}, {1'b1, v});
        u_host.select(1'b1);
        until_st(ST_STANDBY, 2 * R);
        chk((cyc - t0) inside {[R - 1:R + 1]}, 1'b1);
        fork u_host.pulse(R + 20); join_none
        until_st(ST_HW_RESET, R + 12);
        chk(blk, 1'b1);
        until_st(ST_STANDBY, 30);
        apb(1, EXT_OFFSET, 2, 0, 0);
        apb(1, EXT_OFFSET, 5, 0, 0);
        apb(0, EXT_OFFSET, 0, 32'hFFFF, 2);
        apb(0, STATUS_OFFSET, 0, 32'h60, 32'h60);
        apb(0, 8'h0C, 0, 32'hFFFFFFFF, 0);
        ddn <= 1'b1;
        @(posedge clk);
        ddn <= 1'b0;
        until_st(ST_DEEP_DOWN, 5);
        u_host.pulse(P + 1);
        until_st(ST_STANDBY, W + 8);
        chk({cold, cfg}, {1'b1, v});
        // extension count of two: three ticks in all
        cold_start();
        apb(1, EXT_OFFSET, 2, 0, 0);
        until_st(ST_STANDBY, 2 * S);
        chk((cyc - t0) inside {[S + 3 * T:S + 3 * T + 5]}, 1'b1);
        // supply dip mid-settle leaves power-on unfinished
        cold_start();
        repeat (S / 2) @(posedge clk);
        pg <= 1'b0;
        repeat (4) @(posedge clk);
        pg <= 1'b1;
        until_st(ST_STANDBY, 2 * S);
        u_host.pulse(P + 1);
        until_st(ST_POR_SETTLE, 6);
        chk(oe, 1'b1);
        test_done();
    end

    initial begin
        #(25 * 3000);
        chk(1, 0);
        test_done();
    end
endmodule
